// ### logic/twio_pkg.sv
package twio_pkg;

    // ------------------------------------------------------------------
    // Word and character geometry
    // ------------------------------------------------------------------
    localparam int unsigned WORD_W = 40;
    localparam int unsigned ROW_W = 4;
    localparam logic [3:0] ROWS_PER_WORD = 4'ha;
    localparam logic [5:0] SHIFT_TARGET = 6'h28;
    localparam logic [2:0] PRINT_SLOTS = 3'h7;

    // ------------------------------------------------------------------
    // Print frame timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned SLOT_MS = 20;
    localparam int unsigned SLOT_CYC_DEF = CLK_HZ / 1000 * SLOT_MS;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [WORD_W-1:0] WORD_RST = 40'h00_0000_0000;

    typedef enum logic [2:0] {
        TWIO_IDLE = 3'h0,
        TWIO_RD_ROW = 3'h1,
        TWIO_RD_END = 3'h3,
        TWIO_PR_SLOT = 3'h2,
        TWIO_PR_NEXT = 3'h6
    } twio_state_t;

    typedef struct packed {
        logic stop_ph;
        logic start_ph;
        logic [4:0] seg;
        logic [4:0] pins;
        logic tape_end;
    } twio_reader_t;

endpackage

// ### logic/twio_top.sv
`timescale 1ns/1ps
//
// Behaviour
// - Input order assembles 40-bit word, ten rows.
// - Each row: shift left, load low four.
// - Print sends ten hex characters, sign first.
// - Withdrawn run request never halts a revolution.
// - Row bits only set ones; cleared first.
// - Load row bits at phase five.
// - Shift count forty raises recognize.
// - Eleventh row separator stops reader, tape end.
// - Print frame: stop, start, five 20 ms times.
module twio_top
    import twio_pkg::*;
#(
    parameter int unsigned SLOT_CYC = SLOT_CYC_DEF
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic IN_ORDER,
    input wire logic PRINT_ORDER,
    input wire logic [WORD_W-1:0] PRINT_WORD,
    input wire twio_reader_t RDR,
    output logic RDR_RUN,
    output logic [WORD_W-1:0] ACC_WORD,
    output logic ACC_VALID,
    input wire logic ACC_READY,
    output logic RECOGNIZE,
    output logic PRINT_LINE,
    output logic BUSY,
    output logic DONE
);

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    twio_state_t state_r, state_nxt;
    logic [WORD_W-1:0] acc_r, acc_nxt;
    logic [WORD_W-1:0] prw_r, prw_nxt;
    logic [5:0] shifts_r, shifts_nxt;
    logic [3:0] rows_r, rows_nxt;
    logic [3:0] chars_r, chars_nxt;
    logic [2:0] slot_r, slot_nxt;
    logic [31:0] tick_r, tick_nxt;
    logic [4:0] seg_d_r, seg_d_nxt;
    logic run_r, run_nxt, rec_r, rec_nxt, line_r, line_nxt;
    logic done_r, done_nxt, push, busy_r, busy_nxt;

    // Two-entry buffer towards the word consumer.
    logic [WORD_W-1:0] buf_r [2];
    logic [WORD_W-1:0] buf_nxt [2];
    logic [1:0] cnt_r, cnt_nxt;
    logic valid_r, valid_nxt;

    logic buf_room;
    assign buf_room = (cnt_r != 2'h2);

    always_comb begin
        state_nxt = state_r;
        acc_nxt = acc_r;
        prw_nxt = prw_r;
        shifts_nxt = shifts_r;
        rows_nxt = rows_r;
        chars_nxt = chars_r;
        slot_nxt = slot_r;
        tick_nxt = tick_r;
        seg_d_nxt = RDR.seg;
        run_nxt = run_r;
        rec_nxt = rec_r;
        line_nxt = line_r;
        done_nxt = 1'b0;
        push = 1'b0;
        case (state_r)
            TWIO_IDLE: begin
                line_nxt = 1'b1;
                if (IN_ORDER && buf_room) begin
                    // The whole word is cleared so single-sided loads work.
                    acc_nxt = WORD_RST;
                    shifts_nxt = 6'h00;
                    rows_nxt = 4'h0;
                    rec_nxt = 1'b0;
                    run_nxt = 1'b1;
                    state_nxt = TWIO_RD_ROW;
                end else if (PRINT_ORDER) begin
                    prw_nxt = PRINT_WORD;
                    chars_nxt = 4'h0;
                    slot_nxt = 3'h0;
                    tick_nxt = 32'h0;
                    state_nxt = TWIO_PR_SLOT;
                end
            end
            TWIO_RD_ROW: begin
                // Shift on each rising edge of phases one to four.
                if (|(RDR.seg[3:0] & ~seg_d_r[3:0])
                        && shifts_r != SHIFT_TARGET) begin
                    acc_nxt = {acc_r[WORD_W-2:0], 1'b0};
                    shifts_nxt = shifts_r + 6'h01;
                    if (shifts_r + 6'h01 == SHIFT_TARGET)
                        rec_nxt = 1'b1;
                end
                if (RDR.seg[4] && !seg_d_r[4]) begin
                    acc_nxt = acc_r | {36'h0, RDR.pins[3:0]};
                    rows_nxt = rows_r + 4'h1;
                    if (rows_r + 4'h1 == ROWS_PER_WORD)
                        state_nxt = TWIO_RD_END;
                end
            end
            TWIO_RD_END: begin
                // The reader owns the stop; only its tape end ends the order.
                if (RDR.tape_end) begin
                    run_nxt = 1'b0;
                    push = 1'b1;
                    done_nxt = 1'b1;
                    state_nxt = TWIO_IDLE;
                end
            end
            TWIO_PR_SLOT: begin
                // Slot 0 stop (mark), slot 1 start (space), then five digits.
                case (slot_r)
                    3'h0: line_nxt = 1'b1;
                    3'h1: line_nxt = 1'b0;
                    3'h2: line_nxt = 1'b0;
                    default: line_nxt = prw_r[WORD_W-1];
                endcase
                if (tick_r == SLOT_CYC - 1) begin
                    tick_nxt = 32'h0;
                    if (slot_r >= 3'h3)
                        prw_nxt = {prw_r[WORD_W-2:0], 1'b0};
                    if (slot_r == PRINT_SLOTS - 3'h1)
                        state_nxt = TWIO_PR_NEXT;
                    else
                        slot_nxt = slot_r + 3'h1;
                end else begin
                    tick_nxt = tick_r + 32'h1;
                end
            end
            TWIO_PR_NEXT: begin
                slot_nxt = 3'h0;
                line_nxt = 1'b1;
                chars_nxt = chars_r + 4'h1;
                if (chars_r + 4'h1 == ROWS_PER_WORD) begin
                    done_nxt = 1'b1;
                    state_nxt = TWIO_IDLE;
                end else begin
                    state_nxt = TWIO_PR_SLOT;
                end
            end
            default: state_nxt = TWIO_IDLE;
        endcase
        busy_nxt = (state_nxt != TWIO_IDLE);
    end

    // ------------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------------
    always_comb begin
        buf_nxt[0] = buf_r[0];
        buf_nxt[1] = buf_r[1];
        cnt_nxt = cnt_r;
        if (ACC_READY && cnt_r != 2'h0) begin
            buf_nxt[0] = buf_r[1];
            cnt_nxt = cnt_r - 2'h1;
        end
        if (push) begin
            buf_nxt[cnt_nxt[0]] = acc_r;
            cnt_nxt = cnt_nxt + 2'h1;
        end
        // Registered so the consumer never sees the count compare glitch.
        valid_nxt = (cnt_nxt != 2'h0);
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_r <= TWIO_IDLE;
            acc_r <= WORD_RST;
            prw_r <= WORD_RST;
            shifts_r <= 6'h00;
            rows_r <= 4'h0;
            chars_r <= 4'h0;
            slot_r <= 3'h0;
            tick_r <= 32'h0;
            seg_d_r <= 5'h00;
            run_r <= 1'b0;
            rec_r <= 1'b0;
            line_r <= 1'b1;
            done_r <= 1'b0;
            buf_r[0] <= WORD_RST;
            buf_r[1] <= WORD_RST;
            cnt_r <= 2'h0;
            valid_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            acc_r <= acc_nxt;
            prw_r <= prw_nxt;
            shifts_r <= shifts_nxt;
            rows_r <= rows_nxt;
            chars_r <= chars_nxt;
            slot_r <= slot_nxt;
            tick_r <= tick_nxt;
            seg_d_r <= seg_d_nxt;
            run_r <= run_nxt;
            rec_r <= rec_nxt;
            line_r <= line_nxt;
            done_r <= done_nxt;
            buf_r[0] <= buf_nxt[0];
            buf_r[1] <= buf_nxt[1];
            cnt_r <= cnt_nxt;
            valid_r <= valid_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign RDR_RUN = run_r;
    assign ACC_WORD = buf_r[0];
    assign ACC_VALID = valid_r;
    assign RECOGNIZE = rec_r;
    assign PRINT_LINE = line_r;
    assign BUSY = busy_r;
    assign DONE = done_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    a_shift_count_cap: assert property (
        shifts_r <= SHIFT_TARGET) else $error("shift count above forty");
    a_recognize_at_forty: assert property (
        $rose(rec_r) |-> shifts_r == SHIFT_TARGET)
        else $error("recognize without forty shifts");
    a_done_needs_end: assert property (
        (done_r && $past(state_r) == TWIO_RD_END) |-> $past(RDR.tape_end))
        else $error("input done without tape end");
    a_row_load_or: assert property (
        (state_r == TWIO_RD_ROW && RDR.seg[4] && !seg_d_r[4]
            && !(|(RDR.seg[3:0] & ~seg_d_r[3:0])))
        |=> acc_r[3:0] == ($past(acc_r[3:0]) | $past(RDR.pins[3:0])))
        else $error("row bits not gated");
    a_clear_on_start: assert property (
        (state_r == TWIO_IDLE && IN_ORDER && buf_room) |=> acc_r == WORD_RST)
        else $error("accumulator not cleared");
    a_ten_rows: assert property (
        $rose(state_r == TWIO_RD_END) |-> rows_r == ROWS_PER_WORD)
        else $error("input ended before ten rows");
    a_start_space: assert property (
        (state_r == TWIO_PR_SLOT && slot_r == 3'h1) |=> !line_r)
        else $error("start part not a space");
    a_idle_mark: assert property (
        (state_r == TWIO_IDLE && $past(state_r) == TWIO_IDLE) |-> line_r)
        else $error("line not at rest");

    c_input_done: cover property (done_r && $past(state_r) == TWIO_RD_END);
    c_print_done: cover property (done_r && $past(state_r) == TWIO_PR_NEXT);
    c_buf_full: cover property (cnt_r == 2'h2);
    c_recognize: cover property ($rose(rec_r));

endmodule // twio_top

// ### testbench/twio_reader_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------------------
// Tape reader stand-in.
// --------------------------------------------------------------------
module twio_reader_model
    import twio_pkg::*;
(
    input wire logic clk,
    input wire logic run,
    input wire logic [WORD_W-1:0] tape_word,
    input wire logic [31:0] ph_len,
    output twio_reader_t rdr
);
    logic [4:0] last;
    task automatic hold();
        repeat (ph_len) @(negedge clk);
    endtask
    initial begin
        last = 5'h0a;
        rdr = '{1'b1, 1'b0, 5'h00, 5'h15, 1'b0};
        forever begin
            @(negedge clk);
            if (run) begin
                for (int r = 0; r < 11; r++) begin
                    hold();
                    last = 5'h1f;
                    if (r < 10) begin
                        last = {1'b0, tape_word[39-4*r -: 4]};
                    end
                    rdr.stop_ph = 1'b0;
                    rdr.start_ph = 1'b1;
                    rdr.pins = last;
                    hold();
                    rdr.start_ph = 1'b0;
                    rdr.stop_ph = (r == 10);
                    if (r == 10) break;
                    for (int s = 0; s < 5; s++) begin
                        rdr.seg = 5'h01 << s;
                        hold();
                    end
                    rdr.seg = 5'h00;
                    rdr.stop_ph = 1'b1;
                    // Retracted pins show garbage, never the old row.
                    rdr.pins = ~last;
                end
                rdr.tape_end = 1'b1;
                while (run) @(negedge clk);
                rdr.tape_end = 1'b0;
                rdr.pins = ~last;
            end
        end
    end
endmodule // twio_reader_model

// ### testbench/tape_word_input_output_tb.sv
`timescale 1ns/1ps
// --------------------------------------------------------------------
// Self-checking bench.
// --------------------------------------------------------------------
module tape_word_input_output_tb;
    import twio_pkg::*;
    localparam int unsigned SC = 4;
    logic mclk, rst, in_order, print_order, acc_ready;
    logic rdr_run, acc_valid, recognize, print_line, busy, done;
    logic [WORD_W-1:0] print_word, tape_word, acc_word, w0, w1;
    twio_reader_t rdr;
    int ph_len, mismatches, n_checks;
    logic [WORD_W-1:0] exp_q[$];

    twio_top #(.SLOT_CYC(SC)) uut (.MCLK(mclk), .RST(rst),
        .IN_ORDER(in_order), .PRINT_ORDER(print_order),
        .PRINT_WORD(print_word), .RDR(rdr), .RDR_RUN(rdr_run),
        .ACC_WORD(acc_word), .ACC_VALID(acc_valid),
        .ACC_READY(acc_ready), .RECOGNIZE(recognize),
        .PRINT_LINE(print_line), .BUSY(busy), .DONE(done));
    twio_reader_model rdr_m (.clk(mclk), .run(rdr_run),
        .tape_word(tape_word), .ph_len(ph_len), .rdr(rdr));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(string nm, logic [WORD_W-1:0] s, logic [WORD_W-1:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 5000) begin
            @(negedge mclk);
            n++;
        end
        chk("done", WORD_W'(done), 40'h1);
    endtask

    task automatic read_word(logic [WORD_W-1:0] w, int len);
        logic [WORD_W-1:0] m;
        m = '0;
        tape_word = w;
        ph_len = len;
        in_order = 1'b1;
        @(negedge mclk);
        in_order = 1'b0;
        chk("run_on", WORD_W'(rdr_run), 40'h1);
        chk("rec_clr", WORD_W'(recognize), 40'h0);
        chk("busy", WORD_W'(busy), 40'h1);
        wait_done();
        for (int r = 0; r < 10; r++) begin
            m = (m << 4) | WORD_W'(w[39-4*r -: 4]);
        end
        exp_q.push_back(m);
        chk("recognize", WORD_W'(recognize), 40'h1);
        @(negedge mclk);
        chk("run", WORD_W'(rdr_run), 40'h0);
    endtask

    task automatic print_chk(logic [WORD_W-1:0] w);
        int n;
        print_word = w;
        print_order = 1'b1;
        @(negedge mclk);
        print_order = 1'b0;
        for (int c = 0; c < 10; c++) begin
            n = 0;
            while (print_line !== 1'b1 && n < 200) begin
                @(negedge mclk);
                n++;
            end
            while (print_line !== 1'b0 && n < 400) begin
                @(negedge mclk);
                n++;
            end
            repeat (SC + SC / 2) @(negedge mclk);
            chk("digit1", WORD_W'(print_line), 40'h0);
            for (int b = 0; b < 4; b++) begin
                repeat (SC) @(negedge mclk);
                chk("pbit", WORD_W'(print_line), WORD_W'(w[39-4*c-b]));
            end
        end
        wait_done();
    endtask

    initial begin
        rst = 1'b1;
        in_order = 1'b0;
        print_order = 1'b0;
        acc_ready = 1'b0;
        print_word = '0;
        tape_word = '0;
        ph_len = 2;
        mismatches = 0;
        n_checks = 0;
        void'($urandom(57));
        w0 = {8'($urandom()), $urandom()};
        w1 = {8'($urandom()), $urandom()};
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        chk("valid_rst", WORD_W'(acc_valid), 40'h0);
        chk("line_rst", WORD_W'(print_line), 40'h1);
        chk("busy_rst", WORD_W'(busy), 40'h0);
        read_word(w0, 2);
        // The complement word exposes bits left over from the last word.
        read_word(~w0, 5);
        in_order = 1'b1;
        repeat (3) @(negedge mclk);
        chk("full_refuse", WORD_W'(busy), 40'h0);
        print_chk(w1);
        in_order = 1'b0;
        acc_ready = 1'b1;
        for (int i = 0; i < 2; i++) begin
            chk("valid", WORD_W'(acc_valid), 40'h1);
            chk("acc_word", acc_word, exp_q.pop_front());
            @(negedge mclk);
        end
        acc_ready = 1'b0;
        chk("empty", WORD_W'(acc_valid), 40'h0);
        print_chk(40'h80_0000_0001);
        conclude();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        conclude();
    end
endmodule // tape_word_input_output_tb
